// file: rtl/pwlfe_pkg.sv
// Notes on behaviour
// RULE_01: table half-width is a power of two
// RULE_02: table range symmetric about zero
// RULE_03: stored offset shifts input before lookup
// RULE_04: 128 segments, 64 per half
// RULE_05: segment starts at half-width over 64
// RULE_06: between starts, use containing segment's line
// RULE_07: input at range ends gives infinity
// RULE_08: only 15 input bits reach evaluator
// RULE_09: tables downloaded before any use
// RULE_10: up to 32 independent function tables
// RULE_11: evaluation takes about 18 microseconds
// RULE_12: index from top bits; slope*x plus intercept
package pwlfe_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int NUM_FUNC = 32;
    localparam int FUNC_W = 5;
    localparam int NUM_SEG = 128;
    localparam int HALF_SEG = 64;
    localparam int SEG_W = 7;
    localparam int X_W = 32;
    localparam int X_FRAC = 16;
    localparam int XQ_W = 15;
    localparam int SLOPE_W = 16;
    localparam int ICPT_W = 32;
    localparam int RES_W = 32;
    localparam int CODE_W = 5;
    // range code c means half-width 2**(c-3): 0 gives 0.125, 4 gives 2
    localparam logic [4:0] RANGE_CODE_MAX = 5'h11;
    localparam logic [4:0] RANGE_CODE_RESET = 5'h04;
    // ****************************************
    // timing
    // ****************************************
    localparam int EVAL_TIME_NS = 18000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int EVAL_CYC = EVAL_TIME_NS / CLK_PERIOD_NS;
    localparam logic [11:0] CNT_RESET = 12'h000;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic cfg;
        logic [FUNC_W-1:0] func;
        logic [SEG_W-1:0] seg;
        logic [SLOPE_W-1:0] slope;
        logic [ICPT_W-1:0] icpt;
        logic [X_W-1:0] offset;
        logic [CODE_W-1:0] range_code;
    } pwlfe_dl_t;
    typedef struct packed {
        logic [SLOPE_W-1:0] slope;
        logic [ICPT_W-1:0] icpt;
    } pwlfe_entry_t;
    typedef struct packed {
        logic [RES_W-1:0] value;
        logic infinite;
        logic undefined;
    } pwlfe_res_t;
endpackage

// file: rtl/pwlfe_mac.sv
`timescale 1ns/1ps
module pwlfe_mac (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic go_in,
    input wire logic [pwlfe_pkg::SLOPE_W-1:0] slope_in,
    input wire logic [pwlfe_pkg::XQ_W-1:0] x_in,
    input wire logic [pwlfe_pkg::ICPT_W-1:0] icpt_in,
    output logic [pwlfe_pkg::RES_W-1:0] y_out
);
    // ****************************************
    // slope times x plus intercept
    // ****************************************
    logic signed [pwlfe_pkg::SLOPE_W+pwlfe_pkg::XQ_W-1:0] prod;
    logic signed [pwlfe_pkg::RES_W-1:0] next_y;

    // sum wraps at result width; tables must keep results in range
    always_comb begin
        prod = $signed(slope_in) * $signed(x_in);
        next_y = pwlfe_pkg::RES_W'(prod) + $signed(icpt_in); // RULE_12
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            y_out <= '0;
        end else if (go_in) begin
            y_out <= next_y;
        end
    end
endmodule // pwlfe_mac

// file: rtl/pwlfe_top.sv
`timescale 1ns/1ps
module pwlfe_top #(
    parameter int EVAL_CYC = pwlfe_pkg::EVAL_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    // function_table_download_command
    input wire logic dl_valid_in,
    input wire pwlfe_pkg::pwlfe_dl_t dl_in,
    // evaluation request from the algorithm engine
    input wire logic ev_valid_in,
    input wire logic [pwlfe_pkg::FUNC_W-1:0] ev_func_in,
    input wire logic [pwlfe_pkg::X_W-1:0] ev_x_in,
    output logic ev_ready_out,
    output logic res_valid_out,
    output pwlfe_pkg::pwlfe_res_t res_out
);
    // ****************************************
    // state and storage
    // ****************************************
    typedef enum logic [2:0] {
        PWLFE_IDLE = 3'b000,
        PWLFE_NORM = 3'b001,
        PWLFE_READ = 3'b010,
        PWLFE_MAC = 3'b011,
        PWLFE_WAIT = 3'b100
    } pwlfe_state_t;

    pwlfe_state_t state;
    logic [11:0] cnt;
    logic [pwlfe_pkg::FUNC_W-1:0] func;
    logic signed [pwlfe_pkg::X_W:0] shifted;
    logic [pwlfe_pkg::XQ_W-1:0] xq;
    logic infinite;
    logic undefined;
    pwlfe_pkg::pwlfe_entry_t entry;
    // result fields, joined into res_out by one assignment below
    logic [pwlfe_pkg::RES_W-1:0] mac_y;
    logic res_inf;
    logic res_und;

    // one segment table per function, 32 x 128 entries
    pwlfe_pkg::pwlfe_entry_t seg_mem [pwlfe_pkg::NUM_FUNC*pwlfe_pkg::NUM_SEG];
    logic [pwlfe_pkg::X_W-1:0] offset_mem [pwlfe_pkg::NUM_FUNC];
    logic [pwlfe_pkg::CODE_W-1:0] code_mem [pwlfe_pkg::NUM_FUNC];
    logic [pwlfe_pkg::NUM_FUNC-1:0] defined;

    localparam logic signed [34:0] NORM_LIM = 35'sh000008000;
    localparam logic [11:0] LAST_CNT = 12'(EVAL_CYC - 1);

    logic signed [34:0] pre;
    logic signed [34:0] norm;
    logic [4:0] code;
    logic [pwlfe_pkg::SEG_W-1:0] seg;

    // ****************************************
    // table download
    // ****************************************
    // segment entries, addressed by function then segment
    always_ff @(posedge clk_in) begin
        if (dl_valid_in && !dl_in.cfg) begin
            seg_mem[{dl_in.func, dl_in.seg}] <= {dl_in.slope, dl_in.icpt}; // RULE_10
        end
    end

    // per-function offset and power-of-two range
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < pwlfe_pkg::NUM_FUNC; i++) begin
                offset_mem[i] <= '0;
                code_mem[i] <= pwlfe_pkg::RANGE_CODE_RESET;
            end
        end else if (dl_valid_in && dl_in.cfg) begin
            offset_mem[dl_in.func] <= dl_in.offset; // RULE_03
            // oversized codes clamp to the widest range
            if (dl_in.range_code > pwlfe_pkg::RANGE_CODE_MAX) begin
                code_mem[dl_in.func] <= pwlfe_pkg::RANGE_CODE_MAX; // RULE_01
            end else begin
                code_mem[dl_in.func] <= dl_in.range_code; // RULE_01
            end
        end
    end

    // a function becomes callable once its range is downloaded
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            defined <= '0;
        end else if (dl_valid_in && dl_in.cfg) begin
            defined[dl_in.func] <= 1'b1; // RULE_09
        end
    end

    // ****************************************
    // normalisation
    // ****************************************
    // scale so that the half-width lands on 2**15, symmetric about zero;
    // the pre-shift by two lets the smallest range code shift right too
    // code is captured with the request, so a late download cannot split it
    always_comb begin
        pre = 35'(shifted) <<< 2;
        norm = pre >>> code; // RULE_02
    end

    // top seven bits of the 15-bit value: sign plus six, 64 per half
    assign seg = xq[pwlfe_pkg::XQ_W-1 -: pwlfe_pkg::SEG_W]; // RULE_04 RULE_05 RULE_12

    // ****************************************
    // sequencing
    // ****************************************
    // fixed latency keeps the algorithm engine's timing independent of data
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= PWLFE_IDLE;
        end else begin
            case (state)
                PWLFE_IDLE: begin
                    if (ev_valid_in) begin
                        state <= PWLFE_NORM;
                    end
                end
                PWLFE_NORM: state <= PWLFE_READ;
                PWLFE_READ: state <= PWLFE_MAC;
                PWLFE_MAC: state <= PWLFE_WAIT;
                PWLFE_WAIT: begin
                    if (cnt == LAST_CNT) begin
                        state <= PWLFE_IDLE; // RULE_11
                    end
                end
                default: state <= PWLFE_IDLE;
            endcase
        end
    end

    // cycles since the request was taken
    // twelve bits limit the latency parameter to 4096 cycles
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= pwlfe_pkg::CNT_RESET;
        end else if (state == PWLFE_IDLE) begin
            cnt <= pwlfe_pkg::CNT_RESET;
        end else begin
            cnt <= cnt + 12'h001; // RULE_11
        end
    end

    // capture request, subtract the function's offset; range and defined
    // state are taken at the same edge, so a range download landing on that edge
    // or later leaves this evaluation alone
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            func <= '0;
            shifted <= '0;
            code <= pwlfe_pkg::RANGE_CODE_RESET;
            undefined <= 1'b0;
        end else if (state == PWLFE_IDLE && ev_valid_in) begin
            func <= ev_func_in;
            shifted <= $signed({ev_x_in[pwlfe_pkg::X_W-1], ev_x_in})
                - $signed({offset_mem[ev_func_in][pwlfe_pkg::X_W-1],
                offset_mem[ev_func_in]}); // RULE_03
            code <= code_mem[ev_func_in]; // RULE_01
            undefined <= !defined[ev_func_in]; // RULE_09
        end
    end

    // 15-bit input and range-end detection
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            xq <= '0;
            infinite <= 1'b0;
        end else if (state == PWLFE_NORM) begin
            // drop the lowest bit, like the 16-bit converter path
            xq <= norm[15:1]; // RULE_08
            // at or beyond either end of the range the infinite flag is raised; the value still comes from the fetched line
            infinite <= (norm >= NORM_LIM) || (norm <= -NORM_LIM); // RULE_07
        end
    end

    // segment fetch, one cycle
    // entries are not reset; an unloaded segment reads as unknown
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            entry <= '0;
        end else if (state == PWLFE_READ) begin
            entry <= seg_mem[{func, seg}]; // RULE_06 RULE_12
        end
    end

    pwlfe_mac pwlfe_mac_i (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .go_in(state == PWLFE_MAC),
        .slope_in(entry.slope),
        .x_in(xq),
        .icpt_in(entry.icpt),
        .y_out(mac_y)
    );

    // ****************************************
    // answer
    // ****************************************
    // flags follow the value into the result at the mac stage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_valid_out <= 1'b0;
            res_inf <= 1'b0;
            res_und <= 1'b0;
        end else begin
            res_valid_out <= (state == PWLFE_WAIT) && (cnt == LAST_CNT); // RULE_11
            if (state == PWLFE_MAC) begin
                res_inf <= infinite; // RULE_07
                res_und <= undefined;
            end
        end
    end

    // requests while busy are simply not taken, never queued
    assign ev_ready_out = (state == PWLFE_IDLE);

    // one driver for the whole struct; the value flops live in the mac
    assign res_out = {mac_y, res_inf, res_und};
endmodule // pwlfe_top

// file: verif/pwlfe_top_props.sv
`timescale 1ns/1ps
// ****************
// answer timing checker
// ****************
module pwlfe_top_chk #(
    parameter int EVAL_CYC = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic dl_valid_in,
    input wire pwlfe_pkg::pwlfe_dl_t dl_in,
    input wire logic ev_valid_in,
    input wire logic [pwlfe_pkg::FUNC_W-1:0] ev_func_in,
    input wire logic ev_ready_out,
    input wire logic res_valid_out,
    input wire pwlfe_pkg::pwlfe_res_t res_out
);
    logic take;
    logic und_q;
    logic [11:0] cnt;
    logic [31:0] defd;
    assign take = ev_valid_in && ev_ready_out;
    // cycles left until the answer
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) cnt <= 12'h000;
        else if (take) cnt <= 12'(EVAL_CYC);
        else if (cnt != 12'h000) cnt <= cnt - 12'h001;
    end
    // functions that got a range word
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) defd <= 32'h0;
        else if (dl_valid_in && dl_in.cfg) defd[dl_in.func] <= 1'b1;
    end
    // latched at the take edge, so a later download cannot blur it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) und_q <= 1'b0;
        else if (take) und_q <= !defd[ev_func_in];
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_lat; cnt == 12'h001 |=> res_valid_out; endproperty
    a_lat: assert property (p_lat) else $error("answer not on time");
    property p_rdy; ev_ready_out == (cnt == 12'h000); endproperty
    a_rdy: assert property (p_rdy) else $error("ready wrong");
    property p_pulse; res_valid_out |=> !res_valid_out; endproperty
    a_pulse: assert property (p_pulse) else $error("valid too long");
    property p_when; res_valid_out |-> $past(cnt) == 12'h001; endproperty
    a_when: assert property (p_when) else $error("stray answer");
    property p_hold; cnt != 12'(EVAL_CYC - 3) |-> $stable(res_out); endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_undef; res_valid_out |-> res_out.undefined == und_q; endproperty
    a_undef: assert property (p_undef) else $error("undefined flag wrong");
    property p_rise; $rose(ev_ready_out) |-> res_valid_out; endproperty
    a_rise: assert property (p_rise) else $error("ready without answer");
    property p_drop; take |=> !ev_ready_out; endproperty
    a_drop: assert property (p_drop) else $error("ready stayed high");
    c_take: cover property (take);
    c_inf: cover property (res_valid_out && res_out.infinite);
    c_undef: cover property (res_valid_out && res_out.undefined);
endmodule // pwlfe_top_chk
bind pwlfe_top pwlfe_top_chk #(.EVAL_CYC(EVAL_CYC)) pwlfe_top_chk_i (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .dl_valid_in(dl_valid_in), .dl_in(dl_in), .ev_valid_in(ev_valid_in),
    .ev_func_in(ev_func_in), .ev_ready_out(ev_ready_out), .res_valid_out(res_valid_out),
    .res_out(res_out));

// file: verif/pwlfe_top_test.sv
`timescale 1ns/1ps
module pwlfe_top_test;
    localparam int EC = 8;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic dl_valid_in = 1'b0;
    logic ev_valid_in = 1'b0;
    pwlfe_pkg::pwlfe_dl_t dl_in = '0;
    logic [4:0] ev_func_in = 5'h00;
    logic [31:0] ev_x_in = 32'h0;
    logic ev_ready_out;
    logic res_valid_out;
    pwlfe_pkg::pwlfe_res_t res_out;
    pwlfe_pkg::pwlfe_res_t r;
    int fail_count = 0;
    int n_tests = 0;
    pwlfe_top #(.EVAL_CYC(EC)) pwlfe_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .dl_valid_in(dl_valid_in), .dl_in(dl_in), .ev_valid_in(ev_valid_in),
        .ev_func_in(ev_func_in), .ev_x_in(ev_x_in), .ev_ready_out(ev_ready_out),
        .res_valid_out(res_valid_out), .res_out(res_out));
    // ****************
    // helpers
    // ****************
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic dl(input logic c, input logic [4:0] f, input logic [6:0] s,
        input logic [15:0] sl, input logic [31:0] ic, input logic [31:0] off);
        @(posedge clk_in);
        dl_valid_in <= 1'b1;
        dl_in <= '{c, f, s, sl, ic, off, (f == 5'h1F) ? 5'h03 : 5'h04};
        @(posedge clk_in);
        dl_valid_in <= 1'b0;
    endtask
    // request held until an edge that sees ready, then latency counted
    task automatic eval(input logic [4:0] f, input logic [31:0] x);
        int n;
        logic rdy;
        @(posedge clk_in);
        ev_func_in <= f;
        ev_x_in <= x;
        ev_valid_in <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge clk_in);
            rdy = ev_ready_out;
            @(posedge clk_in);
            if (rdy === 1'b1) break;
        end
        ev_valid_in <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (res_valid_out !== 1'b1 && n < 100);
        check(32'(n), 32'(EC + 1));
        r = res_out;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_undefined();
        dl(1'b0, 5'h03, 7'h00, 16'h0100, 32'h00000700, 32'h0);
        eval(5'h03, 32'h0);
        check(32'(r.undefined), 32'h1);
        check(r.value, 32'h00000700);
    endtask
    task automatic t_segments();
        dl(1'b1, 5'h00, 7'h00, 16'h0000, 32'h0, 32'h0);
        dl(1'b0, 5'h00, 7'h05, 16'h0100, 32'h00001000, 32'h0);
        dl(1'b0, 5'h00, 7'h7F, 16'hFFFE, 32'h00000100, 32'h0);
        eval(5'h00, 32'h00002800);
        check(r.value, 32'h00051000);
        check(32'(r.undefined), 32'h0);
        eval(5'h00, 32'h00002C00);
        check(r.value, 32'h00059000);
        eval(5'h00, 32'h00002801);
        check(r.value, 32'h00051000);
        eval(5'h00, 32'hFFFFF800);
        check(r.value, 32'h00000300);
    endtask
    task automatic t_ends();
        eval(5'h00, 32'h00020000);
        check(32'(r.infinite), 32'h1);
        eval(5'h00, 32'hFFFE0000);
        check(32'(r.infinite), 32'h1);
        eval(5'h00, 32'h0001FFFF);
        check(32'(r.infinite), 32'h0);
    endtask
    // half-width 1 and offset 1.0 on the last table
    task automatic t_offset();
        dl(1'b1, 5'h1F, 7'h00, 16'h0000, 32'h0, 32'h00010000);
        dl(1'b0, 5'h1F, 7'h05, 16'h0100, 32'h00002000, 32'h0);
        eval(5'h1F, 32'h00011400);
        check(r.value, 32'h00052000);
        eval(5'h1F, 32'h00020000);
        check(32'(r.infinite), 32'h1);
        eval(5'h00, 32'h00002800);
        check(r.value, 32'h00051000);
    endtask
    // range code above the widest clamps to half-width 2**14
    task automatic t_clamp();
        @(posedge clk_in);
        dl_valid_in <= 1'b1;
        dl_in <= '{1'b1, 5'h02, 7'h00, 16'h0000, 32'h0, 32'h0, 5'h1F};
        @(posedge clk_in);
        dl_valid_in <= 1'b0;
        eval(5'h02, 32'h40000000);
        check(32'(r.infinite), 32'h1);
        eval(5'h02, 32'h3FFFFFFF);
        check(32'(r.infinite), 32'h0);
    endtask
    // reset in mid-run forgets which functions were defined
    task automatic t_reset();
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        eval(5'h00, 32'h00002800);
        check(32'(r.undefined), 32'h1);
    endtask
    // requests while busy must not queue a second answer
    task automatic t_refused();
        int n;
        @(posedge clk_in);
        ev_valid_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        ev_valid_in <= 1'b0;
        n = 0;
        repeat (3 * EC) begin
            @(negedge clk_in);
            n += int'(res_valid_out === 1'b1);
        end
        check(32'(n), 32'h1);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // watchdog far beyond the few hundred cycles needed
    initial begin
        #(5 * 400 * EC);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_undefined();
        t_segments();
        t_ends();
        t_offset();
        t_clamp();
        t_refused();
        t_reset();
        final_report();
    end
endmodule // pwlfe_top_test
